// >>> logic/fdcrm_map.vh
// Register offsets, fields and reset values for the reset and motor block
`ifndef FDCRM_MAP_VH
`define FDCRM_MAP_VH
`define FDCRM_OFF_DOR 4'h0
`define FDCRM_OFF_RATE 4'h1
`define FDCRM_OFF_CCR 4'h2
`define FDCRM_OFF_MODE 4'h3
`define FDCRM_OFF_FIFO 4'h4
`define FDCRM_OFF_FREEZE 4'h5
`define FDCRM_OFF_TIMING 4'h6
`define FDCRM_OFF_CFG 4'h7
`define FDCRM_OFF_STATUS 4'h8
`define FDCRM_OFF_MUX 4'h9
`define FDCRM_NREGS 4'hA
`define FDCRM_DOR_RST 8'h00
`define FDCRM_RATE_RST 8'h02
`define FDCRM_CCR_RST 8'h02
`define FDCRM_MODE_RST 8'h00
`define FDCRM_FIFO_RST 8'h20
`define FDCRM_FREEZE_RST 8'h00
`define FDCRM_TIMING_RST 8'h00
`define FDCRM_CFG_RST 8'h00
`define FDCRM_MUX_RST 8'h00
`define FDCRM_MTR_LO 4
`define FDCRM_MTR_HI 7
`define FDCRM_CFG_ENC 7
`define FDCRM_MUX_DUAL 0
`define FDCRM_MUX_M0 1
`define FDCRM_MUX_M1 2
`define FDCRM_RESP_OKAY 2'h0
`define FDCRM_RESP_SLVERR 2'h2
`endif

// >>> logic/fdcrm_regmem.v
// Small register memory with registered read port
`timescale 1ns/1ps
`default_nettype none
module fdcrm_regmem (
    // Clock
    input wire aclk,
    input wire ce,
    // Write port
    input wire we,
    input wire [3:0] waddr,
    input wire [7:0] wdata,
    // Read port
    input wire [3:0] raddr,
    output reg [7:0] rdata_r
);
    reg [7:0] mem [0:15];

    always @(posedge aclk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata_r <= mem[raddr];
        end
    end
endmodule // fdcrm_regmem
`default_nettype wire

// >>> logic/fdcrm_top.v
// Floppy controller master reset and motor-select logic with AXI4-Lite
// Operation
// - Master reset high forces idle and all disk outputs inactive.
// - Master reset clears output register and loads rate select and config control registers with 02.
// - Master reset restores extended mode, FIFO setup and freeze parameters.
// - Master reset leaves drive-timing parameters untouched.
// - Master reset loads chip configuration register with its default.
// - Motor enables come from output register bits 7 to 4.
// - Motor enables are active low.
// - Four-drive select bit 7 makes motor outputs carry an encoded value.
// - Motor pins share rate indicator and kbc bit only in dual-serial mode.
`include "fdcrm_map.vh"
`timescale 1ns/1ps
`default_nettype none
module fdcrm_top (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // Chip master reset pin, active high
    input wire chip_master_reset,
    // AXI4-Lite write address
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Drive pins
    output reg [1:0] motor_enable_n,
    output reg rate_indicator_out,
    input wire kbc_port_bit,
    output reg ctrl_idle
);
    localparam ST_IDLE = 2'b00;
    localparam ST_RUN = 2'b01;

    function in_map;
        input [3:0] idx;
        begin
            in_map = (idx < `FDCRM_NREGS);
        end
    endfunction

    // Master reset pin and kbc port bit synchronisers
    reg mr_s1_r;
    reg mr_s2_r;
    reg kb_s1_r;
    reg kb_s2_r;
    always @(posedge aclk) begin
        if (!aresetn) begin
            mr_s1_r <= 1'b0;
            mr_s2_r <= 1'b0;
            kb_s1_r <= 1'b1;
            kb_s2_r <= 1'b1;
        end else if (ce) begin
            mr_s1_r <= chip_master_reset;
            mr_s2_r <= mr_s1_r;
            kb_s1_r <= kbc_port_bit;
            kb_s2_r <= kb_s1_r;
        end
    end
    wire mr = mr_s2_r;

    // Registers
    reg [7:0] dor_r;
    reg [7:0] rate_r;
    reg [7:0] ccr_r;
    reg [7:0] mode_r;
    reg [7:0] fifo_r;
    reg [7:0] freeze_r;
    reg [7:0] cfg_r;
    reg [7:0] mux_r;
    reg [1:0] state_r;

    // Write channel capture, address and data in either order
    reg aw_have_r;
    reg w_have_r;
    reg [3:0] aw_idx_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    // Readies gated by ce so no beat is accepted while frozen
    assign s_axi_awready = ce && !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_have_r && !s_axi_bvalid;
    wire [3:0] aw_idx = aw_have_r ? aw_idx_r : s_axi_awaddr[5:2];
    wire [31:0] w_dat = w_have_r ? w_data_r : s_axi_wdata;
    wire [3:0] w_stb = w_have_r ? w_strb_r : s_axi_wstrb;
    wire aw_ok = aw_have_r || (s_axi_awvalid && s_axi_awready);
    wire w_ok = w_have_r || (s_axi_wvalid && s_axi_wready);
    wire wr_go = aw_ok && w_ok;
    wire wr_en = wr_go && w_stb[0] && in_map(aw_idx);
    wire [7:0] wb = w_dat[7:0];

    // Drive-timing parameters live in memory, untouched by master reset
    wire tim_we = wr_en && (aw_idx == `FDCRM_OFF_TIMING);
    wire [7:0] tim_rd;

    // Read channel: one-cycle memory latency
    reg rd_wait_r;
    reg [3:0] ar_idx_r;
    assign s_axi_arready = ce && !rd_wait_r && !s_axi_rvalid;

    fdcrm_regmem u_mem (
        .aclk(aclk),
        .ce(ce),
        .we(tim_we),
        .waddr(`FDCRM_OFF_TIMING),
        .wdata(wb),
        .raddr(`FDCRM_OFF_TIMING),
        .rdata_r(tim_rd)
    );

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_idx_r <= 4'h0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FDCRM_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= in_map(aw_idx) ? `FDCRM_RESP_OKAY
                                              : `FDCRM_RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_have_r <= 1'b1;
                    aw_idx_r <= s_axi_awaddr[5:2];
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_have_r <= 1'b1;
                    w_data_r <= s_axi_wdata;
                    w_strb_r <= s_axi_wstrb;
                end
            end
        end
    end

    // Control registers and master reset
    always @(posedge aclk) begin
        if (!aresetn || (ce && mr)) begin
            dor_r <= `FDCRM_DOR_RST;
            rate_r <= `FDCRM_RATE_RST;
            ccr_r <= `FDCRM_CCR_RST;
            mode_r <= `FDCRM_MODE_RST;
            fifo_r <= `FDCRM_FIFO_RST;
            freeze_r <= `FDCRM_FREEZE_RST;
            cfg_r <= `FDCRM_CFG_RST;
            mux_r <= `FDCRM_MUX_RST;
            state_r <= ST_IDLE;
        end else if (ce) begin
            case (state_r)
                ST_IDLE: state_r <= ST_RUN;
                ST_RUN: state_r <= ST_RUN;
                default: state_r <= ST_IDLE;
            endcase
            if (wr_en) begin
                case (aw_idx)
                    `FDCRM_OFF_DOR: dor_r <= wb;
                    `FDCRM_OFF_RATE: rate_r <= wb;
                    `FDCRM_OFF_CCR: ccr_r <= wb;
                    `FDCRM_OFF_MODE: mode_r <= wb;
                    `FDCRM_OFF_FIFO: fifo_r <= wb;
                    `FDCRM_OFF_FREEZE: freeze_r <= wb;
                    `FDCRM_OFF_CFG: cfg_r <= wb;
                    `FDCRM_OFF_MUX: mux_r <= wb;
                    default: ;
                endcase
            end
        end
    end

    // Read data path
    reg [7:0] rd_val;
    always @* begin
        case (ar_idx_r)
            `FDCRM_OFF_DOR: rd_val = dor_r;
            `FDCRM_OFF_RATE: rd_val = rate_r;
            `FDCRM_OFF_CCR: rd_val = ccr_r;
            `FDCRM_OFF_MODE: rd_val = mode_r;
            `FDCRM_OFF_FIFO: rd_val = fifo_r;
            `FDCRM_OFF_FREEZE: rd_val = freeze_r;
            `FDCRM_OFF_TIMING: rd_val = tim_rd;
            `FDCRM_OFF_CFG: rd_val = cfg_r;
            `FDCRM_OFF_STATUS: rd_val = {4'h0, kb_s2_r, mr,
                                         motor_enable_n};
            `FDCRM_OFF_MUX: rd_val = mux_r;
            default: rd_val = 8'h00;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_wait_r <= 1'b0;
            ar_idx_r <= 4'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `FDCRM_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                rd_wait_r <= 1'b1;
                ar_idx_r <= s_axi_araddr[5:2];
            end
            if (rd_wait_r) begin
                rd_wait_r <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_val};
                s_axi_rresp <= in_map(ar_idx_r) ? `FDCRM_RESP_OKAY
                                                : `FDCRM_RESP_SLVERR;
            end
        end
    end

    // Motor select decode
    wire [3:0] mtr_bits = dor_r[`FDCRM_MTR_HI:`FDCRM_MTR_LO];
    reg [1:0] mtr_on;
    always @* begin
        if (cfg_r[`FDCRM_CFG_ENC]) begin
            // Encoded: drive number of lowest running motor, plus one, saturating at 3
            casez (mtr_bits)
                4'b???1: mtr_on = 2'b01;
                4'b??10: mtr_on = 2'b10;
                4'b?100: mtr_on = 2'b11;
                4'b1000: mtr_on = 2'b11;
                default: mtr_on = 2'b00;
            endcase
        end else begin
            mtr_on = mtr_bits[1:0];
        end
    end

    wire dual = mux_r[`FDCRM_MUX_DUAL];
    wire m0_alt = dual && mux_r[`FDCRM_MUX_M0];
    wire m1_alt = dual && mux_r[`FDCRM_MUX_M1];

    always @(posedge aclk) begin
        if (!aresetn || (ce && mr)) begin
            motor_enable_n <= 2'b11;
            rate_indicator_out <= 1'b0;
            ctrl_idle <= 1'b1;
        end else if (ce) begin
            ctrl_idle <= (state_r == ST_IDLE);
            motor_enable_n[0] <= m0_alt ? rate_r[0] : ~mtr_on[0];
            motor_enable_n[1] <= m1_alt ? kb_s2_r : ~mtr_on[1];
            rate_indicator_out <= rate_r[0];
        end
    end
endmodule // fdcrm_top
`default_nettype wire

// >>> test/fdcrm_bench.sv
// Self-checking bench for the reset and motor block
`timescale 1ns/1ps
`default_nettype none
`include "fdcrm_map.vh"
module fdcrm_bench;
    logic aclk, aresetn, ce, mr, rate_o, idle, kbc;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, kbc_low;
    logic [1:0] s_axi_bresp, s_axi_rresp, mot_n, rs;
    int error_cnt, samples_checked, cycles;
    fdcrm_top u_fdcrm_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .chip_master_reset(mr), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .motor_enable_n(mot_n), .rate_indicator_out(rate_o),
        .kbc_port_bit(kbc), .ctrl_idle(idle));
    fdcrm_drive_model u_fdcrm_drive_model (.motor_enable_n(mot_n),
        .hold_low(kbc_low), .kbc_port_bit(kbc));
    initial begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        rs = s_axi_bresp;
        #1;
    endtask
    task automatic rdr(input logic [31:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    task automatic t_unenc;
        logic [7:0] dv [5] = '{8'h10, 8'h20, 8'h30, 8'hC0, 8'h00};
        foreach (dv[i]) begin
            wr(`FDCRM_OFF_DOR * 4, {24'h0, dv[i]});
            chk("motor", {30'h0, ~dv[i][5:4]}, {30'h0, mot_n});
        end
        $display("unencoded motor test done");
    endtask
    task automatic t_enc;
        wr(`FDCRM_OFF_CFG * 4, 32'h80);
        wr(`FDCRM_OFF_DOR * 4, 32'h00);
        chk("motor enc none", 32'h3, {30'h0, mot_n});
        wr(`FDCRM_OFF_DOR * 4, 32'h80);
        chk("motor enc drive3", 32'h0, {30'h0, mot_n});
        $display("encoded motor test done");
    endtask
    task automatic t_mr;
        wr(`FDCRM_OFF_TIMING * 4, 32'h5A);
        wr(`FDCRM_OFF_FIFO * 4, 32'h07);
        wr(`FDCRM_OFF_RATE * 4, 32'h01);
        wr(`FDCRM_OFF_CCR * 4, 32'h05);
        wr(`FDCRM_OFF_MODE * 4, 32'h11);
        wr(`FDCRM_OFF_FREEZE * 4, 32'h80);
        @(posedge aclk);
        mr <= 1'h1;
        repeat (6) @(posedge aclk);
        #1;
        chk("mr motor", 32'h3, {30'h0, mot_n});
        chk("mr idle", 32'h1, {31'h0, idle});
        chk("mr rate", 32'h0, {31'h0, rate_o});
        @(posedge aclk);
        mr <= 1'h0;
        repeat (4) @(posedge aclk);
        rdr(`FDCRM_OFF_DOR * 4);
        chk("dor", {24'h0, `FDCRM_DOR_RST}, rd);
        rdr(`FDCRM_OFF_RATE * 4);
        chk("rate", {24'h0, `FDCRM_RATE_RST}, rd);
        rdr(`FDCRM_OFF_CCR * 4);
        chk("ccr", {24'h0, `FDCRM_CCR_RST}, rd);
        rdr(`FDCRM_OFF_MODE * 4);
        chk("mode", {24'h0, `FDCRM_MODE_RST}, rd);
        rdr(`FDCRM_OFF_FREEZE * 4);
        chk("freeze", {24'h0, `FDCRM_FREEZE_RST}, rd);
        rdr(`FDCRM_OFF_FIFO * 4);
        chk("fifo", {24'h0, `FDCRM_FIFO_RST}, rd);
        rdr(`FDCRM_OFF_CFG * 4);
        chk("cfg", {24'h0, `FDCRM_CFG_RST}, rd);
        rdr(`FDCRM_OFF_TIMING * 4);
        chk("timing", 32'h5A, rd);
        $display("master reset test done");
    endtask
    task automatic t_mux;
        wr(`FDCRM_OFF_DOR * 4, 32'h30);
        wr(`FDCRM_OFF_MUX * 4, 32'h06);
        chk("mux off", 32'h0, {30'h0, mot_n});
        wr(`FDCRM_OFF_RATE * 4, 32'h01);
        wr(`FDCRM_OFF_MUX * 4, 32'h07);
        chk("mux on", 32'h3, {30'h0, mot_n});
        @(posedge aclk);
        kbc_low <= 1'h1;
        repeat (4) @(posedge aclk);
        #1;
        chk("mux kbc", 32'h1, {30'h0, mot_n});
        @(posedge aclk);
        kbc_low <= 1'h0;
        wr(`FDCRM_OFF_MUX * 4, 32'h00);
        wr(`FDCRM_OFF_DOR * 4, 32'h00);
        chk("mux clear", 32'h3, {30'h0, mot_n});
        $display("pin sharing test done");
    endtask
    task automatic t_ce;
        wr(`FDCRM_OFF_DOR * 4, 32'h10);
        @(posedge aclk);
        ce <= 1'h0;
        mr <= 1'h1;
        repeat (6) @(posedge aclk);
        #1;
        chk("ce motor", 32'h2, {30'h0, mot_n});
        chk("ce idle", 32'h0, {31'h0, idle});
        @(posedge aclk);
        mr <= 1'h0;
        @(posedge aclk);
        ce <= 1'h1;
        rdr(`FDCRM_OFF_DOR * 4);
        chk("ce dor", 32'h10, rd);
        wr(`FDCRM_OFF_DOR * 4, 32'h00);
        $display("clock enable test done");
    endtask
    task automatic t_bad;
        rdr(32'h28);
        chk("bad rresp", {30'h0, `FDCRM_RESP_SLVERR}, {30'h0, rs});
        chk("bad rdata", 32'h0, rd);
        wr(32'h28, 32'hFF);
        chk("bad bresp", {30'h0, `FDCRM_RESP_SLVERR}, {30'h0, rs});
        $display("unmapped test done");
    endtask
    initial begin
        {aresetn, mr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        kbc_low = 1'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        {error_cnt, samples_checked, cycles} = 0;
        ce = 1'h1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        t_unenc();
        t_enc();
        t_mr();
        t_mux();
        t_ce();
        t_bad();
        end_sim();
    end
endmodule // fdcrm_bench
`default_nettype wire

// >>> test/fdcrm_drive_model.sv
// Drive cable model: pulled-up keyboard port line
`timescale 1ns/1ps
`default_nettype none
module fdcrm_drive_model (
    // Motor lines from the controller
    input wire logic [1:0] motor_enable_n,
    // Far side pulls the shared line low while high
    input wire logic hold_low,
    // Shared port line
    output wire logic kbc_port_bit
);
    // Quasi-bidirectional line idles high through its pull-up
    assign kbc_port_bit = hold_low ? 1'h0 : 1'h1;
endmodule // fdcrm_drive_model
`default_nettype wire

// >>> test/fdcrm_monitor.sv
// Port assertions for the reset and motor block
`timescale 1ns/1ps
`default_nettype none
module fdcrm_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic chip_master_reset,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Drive pins
    input wire logic [1:0] motor_enable_n,
    input wire logic rate_indicator_out,
    input wire logic ctrl_idle
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence mr_held;
        (chip_master_reset && ce) [*4];
    endsequence
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    AST_MR_MOTOR: assert property (mr_held |-> motor_enable_n == 2'h3)
        else $error("motor enable active during master reset");
    AST_MR_IDLE: assert property (mr_held |-> ctrl_idle)
        else $error("controller not idle during master reset");
    AST_MR_RATE: assert property (mr_held |-> !rate_indicator_out)
        else $error("rate indicator not cleared by master reset");
    AST_B_ANSWER: assert property (wr_taken |=> s_axi_bvalid)
        else $error("write response late");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("read data late");
    AST_BV_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    AST_RV_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rvalid))
        else $error("read data dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
endmodule // fdcrm_monitor
bind fdcrm_top fdcrm_monitor u_fdcrm_monitor (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .chip_master_reset(chip_master_reset),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .motor_enable_n(motor_enable_n), .rate_indicator_out(rate_indicator_out),
    .ctrl_idle(ctrl_idle));
`default_nettype wire
